// File: logic/cas_addr_space.sv
/*
  Address formation and space qualification for a 16-bit processor bus.
  Assumes a core presenting one request at a time with valid/ready, and
  an external unit that translates segmented addresses without added cycles.
*/
`timescale 1ns/1ps
`include "cas_params.svh"

// What this block does
// - Four memory spaces: system/normal, code/data
// - Distinct status for data, stack, fetches
// - Status marks I/O, acks, refresh, internal
// - Each space spans the variant's range
// - Form 16-bit or 23-bit logical addresses
// - Bits numbered least to most significant
// - Most significant byte at lowest address
// - Words and instructions sit even-aligned
// - Instructions fetched as whole words
// - No quad-word operands in memory
// - Separate I/O space shown by status
// - I/O addresses are 16 bits
// - I/O address and data share lines
// - One wait cycle, four-cycle I/O
// - Special I/O has its own status
// - Up to 128 segments, each up to 64K
// - Translation adds no cycles
// - Segmented part runs nonsegmented code
// - Variants identical except addressing
// - Segment number 7 bits plus 16-bit offset
module cas_addr_space import cas_pkg::*; #(
  parameter bit SEGMENTED = 1'b1
) (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic req_valid_in,
  input wire cas_req_s req_in,
  output logic req_ready_out,
  output logic req_reject_out,
  output logic [3:0] bus_status_code_out,
  output logic system_mode_out,
  output logic [6:0] segment_out,
  output logic [15:0] muxed_addr_data_lines_out,
  output logic muxed_addr_data_lines_oe_out,
  input wire logic [15:0] muxed_addr_data_lines_in,
  output logic addr_phase_out,
  output logic data_phase_out,
  output logic write_out,
  output logic word_out,
  output logic [15:0] rdata_out,
  output logic rdata_valid_out
);

  function automatic logic [3:0] status_of(input cas_ref_e k);
    unique case (k)
      CAS_REF_DATA: status_of = `CAS_ST_DATA;
      CAS_REF_STACK: status_of = `CAS_ST_STACK;
      CAS_REF_FIRST_FETCH: status_of = `CAS_ST_FIRST_FETCH;
      CAS_REF_LATER_FETCH: status_of = `CAS_ST_LATER_FETCH;
      CAS_REF_IO: status_of = `CAS_ST_IO_STD;
      CAS_REF_IO_SPECIAL: status_of = `CAS_ST_IO_SPECIAL;
      CAS_REF_REFRESH: status_of = `CAS_ST_REFRESH;
      CAS_REF_SEG_TRAP_ACK: status_of = `CAS_ST_SEG_TRAP_ACK;
      CAS_REF_NMI_ACK: status_of = `CAS_ST_NMI_ACK;
      CAS_REF_NVI_ACK: status_of = `CAS_ST_NVI_ACK;
      CAS_REF_VI_ACK: status_of = `CAS_ST_VI_ACK;
      default: status_of = `CAS_ST_INTERNAL;
    endcase
  endfunction : status_of

  cas_state_e state_ff;
  cas_state_e nxt_state;
  cas_bus_s bus_ff;
  cas_bus_s nxt_bus;
  logic [15:0] wdata_ff;
  logic [2:0] cyc_ff;
  logic [2:0] nxt_cyc;
  logic [15:0] rdata_ff;
  logic rdata_valid_ff;

  wire is_fetch = (req_in.kind == CAS_REF_FIRST_FETCH) || (req_in.kind == CAS_REF_LATER_FETCH);
  wire is_io = (req_in.kind == CAS_REF_IO) || (req_in.kind == CAS_REF_IO_SPECIAL);
  wire is_mem = is_fetch || (req_in.kind == CAS_REF_DATA) || (req_in.kind == CAS_REF_STACK);
  wire is_bus = is_mem || is_io;
  // Quads live only in register groups
  wire bad_size = is_bus && (req_in.size == CAS_SIZE_QUAD);
  // Fetches are whole words; byte fetch refused
  wire bad_fetch = is_fetch && (req_in.size != CAS_SIZE_WORD);
  wire refuse = bad_size || bad_fetch;
  // Words, longs and fetches keep bit zero low
  wire force_even = (req_in.size != CAS_SIZE_BYTE) || is_fetch;
  wire [15:0] eff_off = {req_in.offset[15:1], req_in.offset[0] & ~force_even};
  // Nonsegmented mode pins segment to zero: old code runs in one segment
  wire use_seg = SEGMENTED && req_in.seg_mode && is_mem;
  wire [6:0] eff_seg = use_seg ? req_in.segment : 7'h00;
  wire take = (state_ff == CAS_ST_IDLE_S) && req_valid_in;
  wire accept = take && !refuse;
  wire [2:0] len = is_io ? `CAS_IO_CYCLES : `CAS_MEM_CYCLES;

  assign req_ready_out = (state_ff == CAS_ST_IDLE_S);
  assign req_reject_out = take && refuse;

  always_comb begin
    nxt_state = state_ff;
    nxt_bus = bus_ff;
    nxt_cyc = cyc_ff;
    unique case (state_ff)
      CAS_ST_IDLE_S: begin
        nxt_bus.status = `CAS_ST_IDLE;
        if (accept) begin
          nxt_state = CAS_ST_ADDR_S;
          nxt_bus.status = status_of(req_in.kind);
          nxt_bus.system_mode = req_in.system_mode;
          nxt_bus.segment = eff_seg;
          nxt_bus.address = eff_off;
          nxt_bus.write = req_in.write && !is_fetch;
          nxt_bus.word = force_even;
          nxt_cyc = len;
        end
      end
      CAS_ST_ADDR_S: begin
        nxt_state = (cyc_ff == `CAS_IO_CYCLES) ? CAS_ST_WAIT_S : CAS_ST_DATA_S;
        nxt_cyc = cyc_ff - 3'h1;
      end
      CAS_ST_WAIT_S: begin
        nxt_state = CAS_ST_DATA_S;
        nxt_cyc = cyc_ff - 3'h1;
      end
      CAS_ST_DATA_S: begin
        nxt_cyc = cyc_ff - 3'h1;
        if (cyc_ff == 3'h1) begin
          nxt_state = CAS_ST_IDLE_S;
          nxt_bus.status = `CAS_ST_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      state_ff <= CAS_ST_IDLE_S;
      bus_ff <= '0;
      cyc_ff <= 3'h0;
      wdata_ff <= 16'h0000;
    end else begin
      state_ff <= nxt_state;
      bus_ff <= nxt_bus;
      cyc_ff <= nxt_cyc;
      if (accept) wdata_ff <= req_in.wdata;
    end
  end

  wire in_data = (state_ff == CAS_ST_DATA_S);
  wire last_data = in_data && (cyc_ff == 3'h1);
  // Byte reads take the lane picked by bit zero; even byte is the high lane
  wire [15:0] rd_pick = bus_ff.word ? muxed_addr_data_lines_in :
                        (bus_ff.address[0] ? {8'h00, muxed_addr_data_lines_in[7:0]} :
                         {8'h00, muxed_addr_data_lines_in[15:8]});

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      rdata_ff <= 16'h0000;
      rdata_valid_ff <= 1'b0;
    end else begin
      rdata_valid_ff <= last_data && !bus_ff.write;
      if (last_data && !bus_ff.write) rdata_ff <= rd_pick;
    end
  end

  // Same lines carry address, then data; a write drives data, a read releases
  wire [15:0] wr_lane = bus_ff.word ? wdata_ff : {wdata_ff[7:0], wdata_ff[7:0]};
  assign addr_phase_out = (state_ff == CAS_ST_ADDR_S);
  assign data_phase_out = in_data;
  assign muxed_addr_data_lines_out = addr_phase_out ? bus_ff.address : wr_lane;
  assign muxed_addr_data_lines_oe_out = addr_phase_out || (in_data && bus_ff.write);
  // Segment number leaves in the same cycle: translation costs nothing here
  assign segment_out = bus_ff.segment;
  assign bus_status_code_out = bus_ff.status;
  assign system_mode_out = bus_ff.system_mode;
  assign write_out = bus_ff.write;
  assign word_out = bus_ff.word;
  assign rdata_out = rdata_ff;
  assign rdata_valid_out = rdata_valid_ff;

  // Busy length count; a stuck access would never bring ready back
  logic [3:0] busy_cnt_ff;
  logic [3:0] nxt_busy_cnt;
  assign nxt_busy_cnt = req_ready_out ? 4'h0 : busy_cnt_ff + 4'h1;
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      busy_cnt_ff <= 4'h0;
    end else begin
      busy_cnt_ff <= nxt_busy_cnt;
    end
  end

  a_io_four_cycles: assert property (@(posedge clk_in) disable iff (rst_in)
    (accept && is_io) |=> addr_phase_out ##1 (state_ff == CAS_ST_WAIT_S) ##1
    data_phase_out ##1 (data_phase_out && cyc_ff == 3'h1))
    else $error("io access not four cycles");
  a_mem_three_cycles: assert property (@(posedge clk_in) disable iff (rst_in)
    (accept && is_mem) |=> addr_phase_out ##1 data_phase_out[*2] ##1 req_ready_out)
    else $error("memory access not three cycles");
  a_busy_bounded: assert property (@(posedge clk_in) disable iff (rst_in)
    busy_cnt_ff <= 4'h4)
    else $error("access runs too long");
  a_busy_exact: assert property (@(posedge clk_in) disable iff (rst_in)
    $rose(req_ready_out) |-> (busy_cnt_ff == 4'h3 || busy_cnt_ff == 4'h4))
    else $error("access length not three or four");
  a_wait_released: assert property (@(posedge clk_in) disable iff (rst_in)
    (!req_ready_out && !addr_phase_out && !data_phase_out) |-> !muxed_addr_data_lines_oe_out)
    else $error("wait cycle drives lines");

  a_even_word_addr: assert property (@(posedge clk_in) disable iff (rst_in)
    (addr_phase_out && bus_ff.word) |-> !muxed_addr_data_lines_out[0])
    else $error("word address odd");
  a_word_attr: assert property (@(posedge clk_in) disable iff (rst_in)
    (accept && force_even) |=> word_out)
    else $error("word attribute missing");
  a_addr_upper_kept: assert property (@(posedge clk_in) disable iff (rst_in)
    accept |=> muxed_addr_data_lines_out[15:1] == $past(req_in.offset[15:1]))
    else $error("address bits lost");
  a_byte_addr_exact: assert property (@(posedge clk_in) disable iff (rst_in)
    (accept && !force_even) |=> muxed_addr_data_lines_out == $past(req_in.offset))
    else $error("byte address altered");

  a_fetch_status: assert property (@(posedge clk_in) disable iff (rst_in)
    (accept && req_in.kind == CAS_REF_FIRST_FETCH) |=> bus_status_code_out == 4'hc)
    else $error("first fetch status wrong");
  a_later_fetch_status: assert property (@(posedge clk_in) disable iff (rst_in)
    (accept && req_in.kind == CAS_REF_LATER_FETCH) |=> bus_status_code_out == 4'hd)
    else $error("later fetch status wrong");
  a_data_status: assert property (@(posedge clk_in) disable iff (rst_in)
    (accept && req_in.kind == CAS_REF_DATA) |=> bus_status_code_out == 4'h8)
    else $error("data status wrong");
  a_stack_status: assert property (@(posedge clk_in) disable iff (rst_in)
    (accept && req_in.kind == CAS_REF_STACK) |=> bus_status_code_out == 4'h9)
    else $error("stack status wrong");
  a_io_status: assert property (@(posedge clk_in) disable iff (rst_in)
    (accept && req_in.kind == CAS_REF_IO) |=> bus_status_code_out == 4'h2)
    else $error("io status wrong");
  a_special_io_code: assert property (@(posedge clk_in) disable iff (rst_in)
    (accept && req_in.kind == CAS_REF_IO_SPECIAL) |=> bus_status_code_out == 4'h3)
    else $error("special io status wrong");
  a_idle_status: assert property (@(posedge clk_in) disable iff (rst_in)
    req_ready_out |-> bus_status_code_out == 4'h0)
    else $error("idle status not zero");
  a_status_held: assert property (@(posedge clk_in) disable iff (rst_in)
    (!req_ready_out && !addr_phase_out) |-> $stable(bus_status_code_out))
    else $error("status moved mid access");
  a_mode_held: assert property (@(posedge clk_in) disable iff (rst_in)
    (!req_ready_out && !addr_phase_out) |-> $stable(system_mode_out))
    else $error("mode moved mid access");

  a_quad_refused: assert property (@(posedge clk_in) disable iff (rst_in)
    (take && bad_size) |=> req_ready_out && bus_status_code_out == 4'h0)
    else $error("quad access issued");
  a_byte_fetch_refused: assert property (@(posedge clk_in) disable iff (rst_in)
    (take && bad_fetch) |-> req_reject_out)
    else $error("byte fetch not refused");
  a_reject_no_issue: assert property (@(posedge clk_in) disable iff (rst_in)
    req_reject_out |=> !addr_phase_out)
    else $error("refused request issued");
  a_fetch_whole_word: assert property (@(posedge clk_in) disable iff (rst_in)
    (addr_phase_out && bus_status_code_out[3:2] == 2'h3) |-> (word_out && !write_out))
    else $error("fetch not a word read");
  a_io_no_segment: assert property (@(posedge clk_in) disable iff (rst_in)
    (accept && is_io) |=> segment_out == 7'h00)
    else $error("io carries segment");
  a_nonseg_zero_seg: assert property (@(posedge clk_in) disable iff (rst_in)
    (accept && !req_in.seg_mode) |=> segment_out == 7'h00)
    else $error("nonsegmented access carries segment");
  a_seg_passed: assert property (@(posedge clk_in) disable iff (rst_in)
    (accept && is_mem && req_in.seg_mode) |=>
    segment_out == (SEGMENTED ? $past(req_in.segment) : 7'h00))
    else $error("segment number lost");

  a_mux_release: assert property (@(posedge clk_in) disable iff (rst_in)
    (data_phase_out && !write_out) |-> !muxed_addr_data_lines_oe_out)
    else $error("read data phase driven");
  a_write_drives: assert property (@(posedge clk_in) disable iff (rst_in)
    (data_phase_out && write_out) |-> muxed_addr_data_lines_oe_out)
    else $error("write data not driven");
  a_addr_drives: assert property (@(posedge clk_in) disable iff (rst_in)
    addr_phase_out |-> muxed_addr_data_lines_oe_out)
    else $error("address not driven");
  a_write_attr: assert property (@(posedge clk_in) disable iff (rst_in)
    (accept && !is_fetch) |=> write_out == $past(req_in.write))
    else $error("direction not carried");
  a_byte_lane_dup: assert property (@(posedge clk_in) disable iff (rst_in)
    (data_phase_out && write_out && !word_out) |->
    muxed_addr_data_lines_out[15:8] == muxed_addr_data_lines_out[7:0])
    else $error("byte write lanes differ");
  a_rdata_pulse: assert property (@(posedge clk_in) disable iff (rst_in)
    rdata_valid_out |-> (req_ready_out && $past(data_phase_out) && !$past(write_out)))
    else $error("read data out of place");
  a_mode_kept: assert property (@(posedge clk_in) disable iff (rst_in)
    accept |=> system_mode_out == $past(req_in.system_mode))
    else $error("mode not carried");

  c_io_read: cover property (@(posedge clk_in) accept && is_io && !req_in.write);
  c_io_write: cover property (@(posedge clk_in) accept && is_io && req_in.write);
  c_seg_fetch: cover property (@(posedge clk_in) accept && is_fetch && use_seg);
  c_byte_write: cover property (@(posedge clk_in)
    accept && req_in.size == CAS_SIZE_BYTE && req_in.write);
  c_refused: cover property (@(posedge clk_in) req_reject_out);

endmodule : cas_addr_space

// File: logic/cas_params.svh
/*
  Constants for the bus address-formation block: status codes, widths, timing.
  Assumes inclusion by the design module only.
*/
`ifndef CAS_PARAMS_SVH
`define CAS_PARAMS_SVH
`define CAS_ST_INTERNAL 4'h0
`define CAS_ST_REFRESH 4'h1
`define CAS_ST_IO_STD 4'h2
`define CAS_ST_IO_SPECIAL 4'h3
`define CAS_ST_SEG_TRAP_ACK 4'h4
`define CAS_ST_NMI_ACK 4'h5
`define CAS_ST_NVI_ACK 4'h6
`define CAS_ST_VI_ACK 4'h7
`define CAS_ST_DATA 4'h8
`define CAS_ST_STACK 4'h9
`define CAS_ST_FIRST_FETCH 4'hc
`define CAS_ST_LATER_FETCH 4'hd
`define CAS_ST_IDLE 4'h0
`define CAS_OFFSET_W 16
`define CAS_SEG_W 7
`define CAS_IO_CYCLES 3'h4
`define CAS_MEM_CYCLES 3'h3
`endif

// File: logic/cas_pkg.sv
/*
  Types for the bus address-formation block.
  Assumes the constants header sits beside it.
*/
package cas_pkg;
  typedef enum logic [3:0] {
    CAS_REF_INTERNAL = 4'h0,
    CAS_REF_REFRESH = 4'h1,
    CAS_REF_IO = 4'h2,
    CAS_REF_IO_SPECIAL = 4'h3,
    CAS_REF_SEG_TRAP_ACK = 4'h4,
    CAS_REF_NMI_ACK = 4'h5,
    CAS_REF_NVI_ACK = 4'h6,
    CAS_REF_VI_ACK = 4'h7,
    CAS_REF_DATA = 4'h8,
    CAS_REF_STACK = 4'h9,
    CAS_REF_FIRST_FETCH = 4'hc,
    CAS_REF_LATER_FETCH = 4'hd
  } cas_ref_e;

  typedef enum logic [1:0] {
    CAS_SIZE_BYTE = 2'h0,
    CAS_SIZE_WORD = 2'h1,
    CAS_SIZE_LONG = 2'h2,
    CAS_SIZE_QUAD = 2'h3
  } cas_size_e;

  typedef struct packed {
    cas_ref_e kind;
    cas_size_e size;
    logic write;
    logic system_mode;
    logic seg_mode;
    logic [6:0] segment;
    logic [15:0] offset;
    logic [15:0] wdata;
  } cas_req_s;

  typedef struct packed {
    logic [3:0] status;
    logic system_mode;
    logic [6:0] segment;
    logic [15:0] address;
    logic write;
    logic word;
  } cas_bus_s;

  typedef enum logic [1:0] {
    CAS_ST_IDLE_S = 2'b00,
    CAS_ST_ADDR_S = 2'b01,
    CAS_ST_WAIT_S = 2'b10,
    CAS_ST_DATA_S = 2'b11
  } cas_state_e;
endpackage : cas_pkg

// File: verification/cas_addr_space_tb_top.sv
/*
  Bench for the bus address-formation block, one task per scenario.
  Assumes the far-side model returns address xor 5a5a on reads.
*/
`timescale 1ns/1ps
module cas_addr_space_tb_top import cas_pkg::*; ;
  logic clk_in, rst_in, req_valid, ready, reject, sysm, oe, aph, dph, wr, wd, rdv;
  cas_req_s req;
  logic [3:0] st;
  logic [6:0] seg;
  logic [15:0] lines, lines_in, rdata;
  int n_mismatch, compares;
  int cyc = 0;
`define CHK(nm, e, g) begin \
  compares++; \
  if ((g) !== (e)) begin \
    n_mismatch++; \
    $display("BAD %s exp %h got %h", nm, e, g); \
  end \
end
  cas_addr_space dut_u (.clk_in(clk_in), .rst_in(rst_in), .req_valid_in(req_valid),
    .req_in(req), .req_ready_out(ready), .req_reject_out(reject),
    .bus_status_code_out(st), .system_mode_out(sysm), .segment_out(seg),
    .muxed_addr_data_lines_out(lines), .muxed_addr_data_lines_oe_out(oe),
    .muxed_addr_data_lines_in(lines_in), .addr_phase_out(aph), .data_phase_out(dph),
    .write_out(wr), .word_out(wd), .rdata_out(rdata), .rdata_valid_out(rdv));
  cas_bus_partner peer_u (.clk_in(clk_in), .rst_in(rst_in), .addr_phase_in(aph),
    .data_phase_in(dph), .write_in(wr), .lines_in(lines), .lines_out(lines_in));
  task automatic close_out();
    $display("Mismatches %0d, compares %0d", n_mismatch, compares);
    if (n_mismatch == 0 && compares > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : close_out
  task automatic xfer(input cas_ref_e k, input cas_size_e sz, input logic w, input logic sm,
      input logic sg, input logic [15:0] off, input logic [15:0] wdat);
    logic io;
    logic [15:0] ea;
    int n;
    logic [15:0] rexp;
    io = (k == CAS_REF_IO) || (k == CAS_REF_IO_SPECIAL);
    ea = (sz == CAS_SIZE_BYTE) ? off : {off[15:1], 1'b0};
    n = 0;
    rexp = ea ^ 16'h5a5a;
    // Odd byte arrives on the low lane, even byte on the high lane
    if (sz == CAS_SIZE_BYTE) begin
      rexp = ea[0] ? {8'h00, rexp[7:0]} : {8'h00, rexp[15:8]};
    end
    @(posedge clk_in);
    #2;
    // Segment field always 55 hex, even where unused
    req = '{kind: k, size: sz, write: w, system_mode: sm, seg_mode: sg, segment: 7'h55,
      offset: off, wdata: wdat};
    req_valid = 1'b1;
    @(posedge clk_in);
    #2;
    req_valid = 1'b0;
    `CHK("status", k, st)
    `CHK("mode", sm, sysm)
    `CHK("segment", (io || !sg) ? 7'h00 : 7'h55, seg)
    `CHK("address", ea, lines)
    `CHK("addr_oe", 1'b1, oe)
    `CHK("word", sz != CAS_SIZE_BYTE, wd)
    `CHK("write", w, wr)
    while (n < 10) begin
      @(posedge clk_in);
      #2;
      n++;
      if (io && n == 1) begin
        `CHK("wait_oe", 1'b0, oe)
      end
      if (n == (io ? 2 : 1)) begin
        `CHK("data_phase", 1'b1, dph)
      end
      if (w && n == (io ? 2 : 1)) begin
        `CHK("wdata", (sz == CAS_SIZE_BYTE) ? {wdat[7:0], wdat[7:0]} : wdat, lines)
        `CHK("data_oe", 1'b1, oe)
      end
      if (ready === 1'b1) begin
        break;
      end
    end
    `CHK("cycles", io ? 4 : 3, n)
    `CHK("rdata_valid", !w, rdv)
    if (!w) begin
      `CHK("rdata", rexp, rdata)
    end
  endtask : xfer
  task automatic t_spaces();
    cas_ref_e kinds[4] = '{CAS_REF_DATA, CAS_REF_STACK, CAS_REF_FIRST_FETCH,
      CAS_REF_LATER_FETCH};
    // Offsets near the top of the range, odd and even
    for (int i = 0; i < 8; i++) begin
      xfer(kinds[i % 4], CAS_SIZE_WORD, 1'b0, i[2], i[0], 16'hfff1 - 16'(i), 16'h0000);
    end
  endtask : t_spaces
  task automatic t_io();
    xfer(CAS_REF_IO, CAS_SIZE_BYTE, 1'b0, 1'b1, 1'b1, 16'hffff, 16'h0000);
    xfer(CAS_REF_IO_SPECIAL, CAS_SIZE_WORD, 1'b0, 1'b1, 1'b1, 16'h0102, 16'h0000);
    xfer(CAS_REF_IO, CAS_SIZE_WORD, 1'b1, 1'b1, 1'b0, 16'h8000, 16'hc3a5);
  endtask : t_io
  task automatic t_writes();
    xfer(CAS_REF_DATA, CAS_SIZE_BYTE, 1'b1, 1'b0, 1'b1, 16'h1233, 16'h00ab);
    xfer(CAS_REF_STACK, CAS_SIZE_LONG, 1'b1, 1'b1, 1'b0, 16'h4001, 16'h9e21);
  endtask : t_writes
  task automatic t_refuse(input cas_ref_e k, input cas_size_e sz);
    @(posedge clk_in);
    #2;
    req.kind = k;
    req.size = sz;
    req_valid = 1'b1;
    #1;
    `CHK("reject", 1'b1, reject)
    @(posedge clk_in);
    #2;
    req_valid = 1'b0;
    `CHK("no_cycle", 1'b0, aph)
  endtask : t_refuse
  initial begin
    clk_in = 1'b0;
    forever #12.5 clk_in = ~clk_in;
  end
  always @(posedge clk_in) begin
    cyc <= cyc + 1;
    // Whole run is about 80 cycles
    if (cyc == 1000) begin
      n_mismatch++;
      close_out();
    end
  end
  initial begin
    rst_in = 1'b1;
    req_valid = 1'b0;
    req = '0;
    n_mismatch = 0;
    compares = 0;
    repeat (3) @(posedge clk_in);
    #2;
    `CHK("rst_status", 4'h0, st)
    `CHK("rst_oe", 1'b0, oe)
    `CHK("rst_rdata", 16'h0000, rdata)
    rst_in = 1'b0;
    t_spaces();
    t_io();
    t_writes();
    t_refuse(CAS_REF_DATA, CAS_SIZE_QUAD);
    t_refuse(CAS_REF_IO, CAS_SIZE_QUAD);
    t_refuse(CAS_REF_FIRST_FETCH, CAS_SIZE_BYTE);
    close_out();
  end
endmodule : cas_addr_space_tb_top

// File: verification/cas_bus_partner.sv
/*
  Far-side memory and I/O model for the bus address-formation block.
  Assumes the block's phase flags, one clock and a zero segment base.
*/
`timescale 1ns/1ps
module cas_bus_partner (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic addr_phase_in,
  input wire logic data_phase_in,
  input wire logic write_in,
  input wire logic [15:0] lines_in,
  output logic [15:0] lines_out
);
  logic [15:0] addr_ff;
  logic [15:0] last_ff;
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      addr_ff <= 16'h0000;
      last_ff <= 16'h0000;
    end else begin
      if (addr_phase_in) begin
        addr_ff <= lines_in;
      end
      last_ff <= lines_out;
    end
  end
  // Base of zero, so the address is taken as is; no added cycles
  // Released lines toggle, never hold a stale value
  assign lines_out = (data_phase_in && !write_in) ? (addr_ff ^ 16'h5a5a) : ~last_ff;
endmodule : cas_bus_partner
